// ==== core/dpr_pkg.sv ====
package dpr_pkg;

    // Memory geometry: 512 words of 32 data plus 4 parity bits
    localparam int          ADDR_W     = 14;
    localparam int          DATA_W     = 32;
    localparam int          PAR_W      = 4;
    localparam int          WORD_W     = 36;
    localparam int          DEPTH      = 512;
    localparam int          IDX_W      = 9;

    // Width select: port width is 1 << sel data bits (1, 2, 4, 8, 16, 32)
    localparam int          SEL_W      = 3;
    localparam logic [2:0]  SEL_MAX    = 3'h5;   // 32 data + 4 parity
    localparam logic [2:0]  SEL_PAR    = 3'h3;   // First width that carries parity

    // Register offsets, byte addresses within the slave
    localparam int          OFF_W      = 12;
    localparam logic [11:0] OFF_CFG_A  = 12'h000;
    localparam logic [11:0] OFF_CFG_B  = 12'h004;
    localparam logic [11:0] OFF_OPCNT  = 12'h008;

    // Port configuration register layout
    localparam int          CFG_W      = 5;
    localparam int          CFG_SEL_LO = 0;
    localparam int          CFG_SEL_HI = 2;
    localparam int          CFG_MODE   = 3;
    localparam int          CFG_POL    = 4;
    localparam logic [4:0]  CFG_RESET  = 5'h05;  // 36 wide, write-through, rising edge

    // Write-mode encodings
    localparam logic        MODE_WRITE_FIRST = 1'b0;
    localparam logic        MODE_READ_FIRST  = 1'b1;

    // Operation counters, port B in the upper half
    localparam int          CNT_W      = 16;

    // AHB-Lite encodings used by the slave
    localparam int          HTRANS_ACT = 1;      // Bit set for NONSEQ and SEQ
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    localparam logic        HRESP_OKAY = 1'b0;

endpackage : dpr_pkg

// ==== core/dpr_req_if.sv ====
`timescale 1ns/1ns
// One port's request toward the memory core, plus its edge polarity back
interface dpr_req_if;
    logic                         fire;      // One-cycle operation strobe
    logic                         we;        // Operation is a write
    logic [dpr_pkg::ADDR_W-1:0]   addr;      // Port address
    logic [dpr_pkg::DATA_W-1:0]   wdata;     // Write data
    logic [dpr_pkg::PAR_W-1:0]    wpar;      // Write parity
    logic                         fall_edge; // Act on falling port clock

    modport port_side (output fire, output we, output addr, output wdata,
                       output wpar, input fall_edge);
    modport core_side (input fire, input we, input addr, input wdata,
                       input wpar, output fall_edge);
endinterface : dpr_req_if

// ==== core/dpr_port.sv ====
`timescale 1ns/1ns
module dpr_port (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic                       pin_clk,
    input  wire logic                       pin_enable,
    input  wire logic                       pin_write_enable,
    input  wire logic [dpr_pkg::ADDR_W-1:0] pin_addr,
    input  wire logic [dpr_pkg::DATA_W-1:0] pin_data,
    input  wire logic [dpr_pkg::PAR_W-1:0]  pin_par,
    dpr_req_if.port_side                    req
);

    // Packed pin bundle: clk, enable, write enable, address, data, parity
    localparam int IN_W = 3 + dpr_pkg::ADDR_W + dpr_pkg::DATA_W + dpr_pkg::PAR_W;

    logic [IN_W-1:0] pin_s1_q;  // First synchroniser stage, read only by stage two
    logic [IN_W-1:0] pin_s2_q;  // Second stage, safe for logic
    logic            clk_s3_q;  // Previous port clock level for edge detect
    logic            clk_now;   // Synchronised port clock
    logic            edge_hit;  // Selected port clock edge seen

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser on every pin, the port clock included
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            clk_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= {pin_clk, pin_enable, pin_write_enable, pin_addr, pin_data, pin_par};
            pin_s2_q <= pin_s1_q;
            clk_s3_q <= pin_s2_q[IN_W-1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detect on the chosen polarity; fields sampled alongside the clock
    assign clk_now  = pin_s2_q[IN_W-1];
    assign edge_hit = req.fall_edge ? (~clk_now & clk_s3_q)
                                    : (clk_now & ~clk_s3_q);
    // Only an enabled port produces an operation
    assign req.fire  = edge_hit & pin_s2_q[IN_W-2];
    assign req.we    = pin_s2_q[IN_W-3];
    assign req.addr  = pin_s2_q[IN_W-4 -: dpr_pkg::ADDR_W];
    assign req.wdata = pin_s2_q[dpr_pkg::PAR_W +: dpr_pkg::DATA_W];
    assign req.wpar  = pin_s2_q[dpr_pkg::PAR_W-1:0];

endmodule : dpr_port

// ==== core/dpr_top.sv ====
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ns
module dpr_top (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    // AHB-Lite register slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [31:0]                     hrdata,
    output logic                            hresp,
    // Port A pins
    input  wire logic                       port_a_clk,
    input  wire logic                       port_a_enable,
    input  wire logic                       port_a_write_enable,
    input  wire logic [dpr_pkg::ADDR_W-1:0] port_a_addr,
    input  wire logic [dpr_pkg::DATA_W-1:0] port_a_write_data_in,
    input  wire logic [dpr_pkg::PAR_W-1:0]  port_a_write_par_in,
    output logic [dpr_pkg::DATA_W-1:0]      port_a_data_out,
    output logic [dpr_pkg::PAR_W-1:0]       port_a_par_out,
    // Port B pins
    input  wire logic                       port_b_clk,
    input  wire logic                       port_b_enable,
    input  wire logic                       port_b_write_enable,
    input  wire logic [dpr_pkg::ADDR_W-1:0] port_b_addr,
    input  wire logic [dpr_pkg::DATA_W-1:0] port_b_write_data_in,
    input  wire logic [dpr_pkg::PAR_W-1:0]  port_b_write_par_in,
    output logic [dpr_pkg::DATA_W-1:0]      port_b_data_out,
    output logic [dpr_pkg::PAR_W-1:0]       port_b_par_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Lane arithmetic shared by both ports

    // Word index: drop the lane bits, keep nine
    function automatic logic [8:0] word_index(input logic [2:0]  sel,
                                              input logic [13:0] addr);
        logic [13:0] shifted;
        shifted = addr >> (dpr_pkg::SEL_MAX - sel);
        return shifted[8:0];
    endfunction : word_index

    // Bit position of the lane inside the 32 data bits
    function automatic logic [4:0] data_pos(input logic [2:0]  sel,
                                            input logic [13:0] addr);
        logic [13:0] lane;
        lane = addr & ((14'h0001 << (dpr_pkg::SEL_MAX - sel)) - 14'h0001);
        lane = lane << sel;
        return lane[4:0];
    endfunction : data_pos

    // Parity lane position: one parity bit per data byte
    function automatic logic [1:0] par_pos(input logic [2:0]  sel,
                                           input logic [13:0] addr);
        logic [4:0] dpos;
        dpos = data_pos(sel, addr) >> dpr_pkg::SEL_PAR;
        return (sel < dpr_pkg::SEL_PAR) ? 2'h0 : dpos[1:0];
    endfunction : par_pos

    // Data bits in use: 1 << sel of them
    function automatic logic [31:0] data_mask(input logic [2:0] sel);
        logic [5:0] dw;
        dw = 6'h01 << sel;
        return ~(32'hFFFF_FFFF << dw);
    endfunction : data_mask

    // Parity bits in use: none below byte width, then 1, 2, 4
    function automatic logic [3:0] par_mask(input logic [2:0] sel);
        logic [2:0] pw;
        pw = 3'h1 << (sel - dpr_pkg::SEL_PAR);
        return (sel < dpr_pkg::SEL_PAR) ? 4'h0 : ~(4'hF << pw);
    endfunction : par_mask

    // Lane read out of a stored word, {parity, data}
    function automatic logic [35:0] extract(input logic [35:0] word,
                                            input logic [2:0]  sel,
                                            input logic [13:0] addr);
        logic [31:0] d;
        logic [3:0]  p;
        d = (word[31:0] >> data_pos(sel, addr)) & data_mask(sel);
        p = (word[35:32] >> par_pos(sel, addr)) & par_mask(sel);
        return {p, d};
    endfunction : extract

    // Lane written into a stored word, other lanes untouched
    function automatic logic [35:0] merge(input logic [35:0] word,
                                          input logic [2:0]  sel,
                                          input logic [13:0] addr,
                                          input logic [31:0] wd,
                                          input logic [3:0]  wp);
        logic [31:0] dm;
        logic [3:0]  pm;
        dm = data_mask(sel) << data_pos(sel, addr);
        pm = par_mask(sel) << par_pos(sel, addr);
        return {(word[35:32] & ~pm) | ((wp & par_mask(sel)) << par_pos(sel, addr)),
                (word[31:0] & ~dm) | ((wd & data_mask(sel)) << data_pos(sel, addr))};
    endfunction : merge

    // Unused width codes fall back to the widest shape
    function automatic logic [2:0] legal_sel(input logic [2:0] sel);
        return (sel > dpr_pkg::SEL_MAX) ? dpr_pkg::SEL_MAX : sel;
    endfunction : legal_sel

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [dpr_pkg::WORD_W-1:0] mem [0:dpr_pkg::DEPTH-1]; // Storage, not reset
    logic [dpr_pkg::CFG_W-1:0]  cfg_a_q;       // Port A shape, mode, polarity
    logic [dpr_pkg::CFG_W-1:0]  cfg_b_q;       // Port B shape, mode, polarity
    logic [dpr_pkg::CNT_W-1:0]  cnt_a_q;       // Port A operations, wraps
    logic [dpr_pkg::CNT_W-1:0]  cnt_b_q;       // Port B operations, wraps
    logic [35:0]                out_a_q;       // Port A output register
    logic [35:0]                out_b_q;       // Port B output register
    logic [2:0]                 sel_a;         // Port A width select
    logic [2:0]                 sel_b;         // Port B width select
    logic [8:0]                 idx_a;         // Port A word
    logic [8:0]                 idx_b;         // Port B word
    logic [35:0]                merged_a;      // Word after port A write
    logic [35:0]                merged_b;      // Word after port B write, built on A's for a shared word
    logic                       addr_ok;       // Valid AHB address phase
    logic                       wr_pend_q;     // Write data phase in progress
    logic [11:0]                wr_off_q;      // Offset of pending write
    logic [31:0]                hrdata_q;      // Registered read data
    logic [dpr_pkg::CFG_W-1:0]  cfg_a_view;    // Port A config incl. pending write
    logic [dpr_pkg::CFG_W-1:0]  cfg_b_view;    // Port B config incl. pending write
    logic [31:0]                rd_val;        // Read mux result

    dpr_req_if req_a ();
    dpr_req_if req_b ();

    ////////////////////////////////////////////////////////////////////////////
    // Port front ends, each sampling its own pins and clock
    dpr_port u_port_a (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .pin_clk          (port_a_clk),
        .pin_enable       (port_a_enable),
        .pin_write_enable (port_a_write_enable),
        .pin_addr         (port_a_addr),
        .pin_data         (port_a_write_data_in),
        .pin_par          (port_a_write_par_in),
        .req              (req_a.port_side)
    );

    dpr_port u_port_b (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .pin_clk          (port_b_clk),
        .pin_enable       (port_b_enable),
        .pin_write_enable (port_b_write_enable),
        .pin_addr         (port_b_addr),
        .pin_data         (port_b_write_data_in),
        .pin_par          (port_b_write_par_in),
        .req              (req_b.port_side)
    );

    // Polarity bits steer each front end
    assign req_a.fall_edge = cfg_a_q[dpr_pkg::CFG_POL];
    assign req_b.fall_edge = cfg_b_q[dpr_pkg::CFG_POL];

    // Shape decode per port
    assign sel_a = cfg_a_q[dpr_pkg::CFG_SEL_HI:dpr_pkg::CFG_SEL_LO];
    assign sel_b = cfg_b_q[dpr_pkg::CFG_SEL_HI:dpr_pkg::CFG_SEL_LO];
    assign idx_a = word_index(sel_a, req_a.addr);
    assign idx_b = word_index(sel_b, req_b.addr);

    ////////////////////////////////////////////////////////////////////////////
    // Memory array

    // Port B builds on port A's result when both write one word in a cycle,
    // so disjoint lanes from both survive; on an overlapping lane B wins
    always_comb begin
        merged_a = merge(mem[idx_a], sel_a, req_a.addr, req_a.wdata, req_a.wpar);
        merged_b = merge((req_a.fire && req_a.we && idx_a == idx_b) ? merged_a : mem[idx_b],
                         sel_b, req_b.addr, req_b.wdata, req_b.wpar);
    end

    // Store on an enabled write; the later assignment carries both writes
    always_ff @(posedge clk_sys) begin
        if (req_a.fire && req_a.we) begin
            mem[idx_a] <= merged_a;
        end
        if (req_b.fire && req_b.we) begin
            mem[idx_b] <= merged_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output registers; reads see the array before this edge's writes

    // Port A output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_a_q <= '0;
        end else if (req_a.fire) begin
            if (req_a.we && cfg_a_q[dpr_pkg::CFG_MODE] == dpr_pkg::MODE_WRITE_FIRST) begin
                out_a_q <= extract({req_a.wpar, req_a.wdata}, sel_a, '0);
            end else begin
                out_a_q <= extract(mem[idx_a], sel_a, req_a.addr);
            end
        end
    end

    // Port B output
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_b_q <= '0;
        end else if (req_b.fire) begin
            if (req_b.we && cfg_b_q[dpr_pkg::CFG_MODE] == dpr_pkg::MODE_WRITE_FIRST) begin
                out_b_q <= extract({req_b.wpar, req_b.wdata}, sel_b, '0);
            end else begin
                out_b_q <= extract(mem[idx_b], sel_b, req_b.addr);
            end
        end
    end

    assign port_a_data_out = out_a_q[31:0];
    assign port_a_par_out  = out_a_q[35:32];
    assign port_b_data_out = out_b_q[31:0];
    assign port_b_par_out  = out_b_q[35:32];

    ////////////////////////////////////////////////////////////////////////////
    // Operation counters, visible to software

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_a_q <= '0;
            cnt_b_q <= '0;
        end else begin
            if (req_a.fire) begin
                cnt_a_q <= cnt_a_q + 16'h0001;
            end
            if (req_b.fire) begin
                cnt_b_q <= cnt_b_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    // Only whole-word transfers are acted on; others complete as no-ops
    assign addr_ok = hsel & hready & htrans[dpr_pkg::HTRANS_ACT] &
                     (hsize == dpr_pkg::HSIZE_WORD);

    // Data phase tracking for writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_off_q  <= '0;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_off_q <= haddr[dpr_pkg::OFF_W-1:0];
            end
        end
    end

    // Configuration registers; a change takes effect on the next operation
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_a_q <= dpr_pkg::CFG_RESET;
            cfg_b_q <= dpr_pkg::CFG_RESET;
        end else begin
            cfg_a_q <= cfg_a_view; // View folds in the pending write
            cfg_b_q <= cfg_b_view;
        end
    end

    // A read right behind a write to the same register sees the new value
    always_comb begin
        cfg_a_view = cfg_a_q;
        cfg_b_view = cfg_b_q;
        if (wr_pend_q && wr_off_q == dpr_pkg::OFF_CFG_A) begin
            cfg_a_view = {hwdata[dpr_pkg::CFG_POL:dpr_pkg::CFG_MODE],
                          legal_sel(hwdata[dpr_pkg::CFG_SEL_HI:dpr_pkg::CFG_SEL_LO])};
        end
        if (wr_pend_q && wr_off_q == dpr_pkg::OFF_CFG_B) begin
            cfg_b_view = {hwdata[dpr_pkg::CFG_POL:dpr_pkg::CFG_MODE],
                          legal_sel(hwdata[dpr_pkg::CFG_SEL_HI:dpr_pkg::CFG_SEL_LO])};
        end
        case (haddr[dpr_pkg::OFF_W-1:0])
            dpr_pkg::OFF_CFG_A: rd_val = {27'h0000000, cfg_a_view};
            dpr_pkg::OFF_CFG_B: rd_val = {27'h0000000, cfg_b_view};
            dpr_pkg::OFF_OPCNT: rd_val = {cnt_b_q, cnt_a_q};
            default:            rd_val = 32'h0000_0000; // Unmapped reads zero
        endcase
    end

    // Read data captured at the address phase, held through the data phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hrdata_q <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= rd_val;
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = dpr_pkg::HRESP_OKAY;

endmodule : dpr_top

// ==== testbench/dpr_checker.sv ====
`timescale 1ns/1ns
// Watch on the memory top's pins
module dpr_checker (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    input wire logic        port_a_clk,
    input wire logic        port_a_enable,
    input wire logic [31:0] port_a_data_out,
    input wire logic [3:0]  port_a_par_out,
    input wire logic        port_b_clk,
    input wire logic        port_b_enable,
    input wire logic [31:0] port_b_data_out,
    input wire logic [3:0]  port_b_par_out
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////
    // Word read taken in an address phase
    logic        rd;
    logic [35:0] oa;    // Port A output word
    logic [35:0] ob;    // Port B output word
    assign rd = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
    assign oa = {port_a_par_out, port_a_data_out};
    assign ob = {port_b_par_out, port_b_data_out};
    ////////////////////////////////////////////////////////////////
    property p_okay; hreadyout && hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("bus not okay");
    property p_hold_rd; !rd |=> $stable(hrdata); endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("read data moved");
    property p_unmap; rd && haddr[11:0] == 12'h00C |=> hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    // Idle port never moves its outputs
    property p_a_idle; !port_a_enable [*4] |=> $stable(oa); endproperty
    a_a_idle: assert property (p_a_idle) else $error("port a moved idle");
    property p_b_idle; !port_b_enable [*4] |=> $stable(ob); endproperty
    a_b_idle: assert property (p_b_idle) else $error("port b moved idle");
    // No pin edge, no operation
    property p_a_still; $stable(port_a_clk) [*4] |=> $stable(oa); endproperty
    a_a_still: assert property (p_a_still) else $error("port a moved, no edge");
    property p_b_still; $stable(port_b_clk) [*4] |=> $stable(ob); endproperty
    a_b_still: assert property (p_b_still) else $error("port b moved, no edge");
    // Change lands three cycles after the sampled pin edge, enable high
    property p_a_ans;
        $changed(oa) |-> $past(port_a_enable, 3) && $past(port_a_clk, 3) != $past(port_a_clk, 4);
    endproperty
    a_a_ans: assert property (p_a_ans) else $error("port a change out of time");
    property p_b_ans;
        $changed(ob) |-> $past(port_b_enable, 3) && $past(port_b_clk, 3) != $past(port_b_clk, 4);
    endproperty
    a_b_ans: assert property (p_b_ans) else $error("port b change out of time");
    c_rd: cover property (rd);
    c_a_op: cover property ($changed(oa));
    c_b_op: cover property ($changed(ob));
endmodule : dpr_checker
bind dpr_top dpr_checker i_dpr_checker (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_a_clk(port_a_clk),
    .port_a_enable(port_a_enable), .port_a_data_out(port_a_data_out),
    .port_a_par_out(port_a_par_out), .port_b_clk(port_b_clk), .port_b_enable(port_b_enable),
    .port_b_data_out(port_b_data_out), .port_b_par_out(port_b_par_out));

// ==== testbench/dpr_user.sv ====
`timescale 1ns/1ns
// User logic on one memory port: one full clock pulse per operation
module dpr_user (
    input  wire logic        clk_sys,
    input  wire logic [31:0] dout,
    output logic             pclk,
    output logic             en,
    output logic             we,
    output logic [13:0]      addr,
    output logic [31:0]      wdata,
    output logic [3:0]       wpar,
    output logic [31:0]      mid
);
    // Clock stands low between operations
    initial begin
        pclk = 1'b0;
        en = 1'b0;
        we = 1'b0;
        addr = 14'h0;
        wdata = 32'h0;
        wpar = 4'h0;
        mid = 32'h0;
    end
    // Setup 3, high 4, hold 4 cycles; enable dropped, other pins inverted once released
    task automatic op(input logic e, input logic w, input logic [13:0] a,
                      input logic [31:0] d, input logic [3:0] p);
        en <= e;
        we <= w;
        addr <= a;
        wdata <= d;
        wpar <= p;
        repeat (3) @(posedge clk_sys);
        pclk <= 1'b1;
        repeat (4) @(posedge clk_sys);
        mid <= dout;    // Output seen before the falling edge
        pclk <= 1'b0;
        repeat (4) @(posedge clk_sys);
        en <= 1'b0;
        we <= ~w;
        addr <= ~a;
        wdata <= ~d;
        wpar <= ~p;
        @(posedge clk_sys);
    endtask : op
endmodule : dpr_user

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic clk_sys = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;   // Whole words only
    logic hreadyout, hresp, a_clk, a_en, a_we, b_clk, b_en, b_we;
    logic [13:0] a_addr, b_addr;
    logic [31:0] a_wd, b_wd, a_do, b_do, b_mid;
    logic [3:0] a_wp, b_wp, a_po, b_po;
    int n_errors = 0;
    int checked = 0;
    always #20 clk_sys = ~clk_sys;
    assign hready = hreadyout;  // Single slave
    dpr_top i_dpr_top (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .port_a_clk(a_clk),
        .port_a_enable(a_en), .port_a_write_enable(a_we), .port_a_addr(a_addr),
        .port_a_write_data_in(a_wd), .port_a_write_par_in(a_wp), .port_a_data_out(a_do),
        .port_a_par_out(a_po), .port_b_clk(b_clk), .port_b_enable(b_en),
        .port_b_write_enable(b_we), .port_b_addr(b_addr), .port_b_write_data_in(b_wd),
        .port_b_write_par_in(b_wp), .port_b_data_out(b_do), .port_b_par_out(b_po));
    dpr_user i_dpr_user_a (.clk_sys(clk_sys), .dout(a_do), .pclk(a_clk), .en(a_en),
        .we(a_we), .addr(a_addr), .wdata(a_wd), .wpar(a_wp), .mid());
    dpr_user i_dpr_user_b (.clk_sys(clk_sys), .dout(b_do), .pclk(b_clk), .en(b_en),
        .we(b_we), .addr(b_addr), .wdata(b_wd), .wpar(b_wp), .mid(b_mid));
    ////////////////////////////////////////////////////////////////
    // Compare a parity-and-data word
    task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One AHB-Lite single transfer; waits on hready
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    // Hang guard; the tests need a few hundred cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);  // Port enables stay low meanwhile
        bus(0, 12'h000, 0);
        chk("cfg a", 36'h05, {4'h0, r});
        bus(0, 12'h004, 0);
        chk("cfg b", 36'h05, {4'h0, r});
        bus(0, 12'h008, 0);
        chk("op count", 36'h0, {4'h0, r});
        bus(1, 12'h00C, 32'hFFFF_FFFF);
        bus(0, 12'h00C, 0);
        chk("unmapped", 36'h0, {4'h0, r});
        $display("registers done");
        // Write-through on A, then the same word read on B
        i_dpr_user_a.op(1, 1, 14'h3, 32'hCAFE_0123, 4'hA);
        chk("a write-through", 36'hA_CAFE_0123, {a_po, a_do});
        i_dpr_user_b.op(1, 0, 14'h3, 32'h0, 4'h0);
        chk("b read", 36'hA_CAFE_0123, {b_po, b_do});
        $display("write-through done");
        // Read-before-write on A
        bus(1, 12'h000, 32'h0D);
        bus(0, 12'h000, 0);
        chk("cfg a mode", 36'h0D, {4'h0, r});
        i_dpr_user_a.op(1, 1, 14'h3, 32'h1357_9BDF, 4'h5);
        chk("a old contents", 36'hA_CAFE_0123, {a_po, a_do});
        i_dpr_user_b.op(1, 0, 14'h3, 32'h0, 4'h0);
        chk("b after a write", 36'h5_1357_9BDF, {b_po, b_do});
        $display("read-before-write done");
        // Disabled write: nothing stored, output holds
        i_dpr_user_a.op(0, 1, 14'h3, 32'hDEAD_BEEF, 4'hF);
        chk("a disabled hold", 36'hA_CAFE_0123, {a_po, a_do});
        i_dpr_user_b.op(1, 0, 14'h3, 32'h0, 4'h0);
        chk("b after disabled", 36'h5_1357_9BDF, {b_po, b_do});
        $display("disable done");
        // Every width on B reads its top lane of a 36-wide word
        i_dpr_user_a.op(1, 1, 14'h5, 32'h9A3C_5E71, 4'hB);
        for (int s = 0; s < 6; s++) begin
            int w, l, pw;
            logic [35:0] e;
            w = 1 << s;
            l = (1 << (5 - s)) - 1;
            pw = (s < 3) ? 0 : 1 << (s - 3);
            e = {4'hB >> (4 - pw), 32'h9A3C_5E71 >> (32 - w)};
            bus(1, 12'h004, 32'(s));
            i_dpr_user_b.op(1, 0, 14'((5 << (5 - s)) | l), 32'h0, 4'h0);
            chk("b lane", e, {b_po, b_do});
        end
        $display("widths done");
        // Falling-edge B: nothing at the rise, write lands at the fall
        bus(1, 12'h004, 32'h15);
        i_dpr_user_b.op(1, 1, 14'h7, 32'h0F1E_2D3C, 4'h6);
        chk("b before fall", {4'h0, 32'h9A3C_5E71}, {4'h0, b_mid});
        chk("b after fall", 36'h6_0F1E_2D3C, {b_po, b_do});
        // Both ports driven together on the same word; A reads at the rise, B at the fall
        fork
            i_dpr_user_a.op(1, 0, 14'h7, 32'h0, 4'h0);
            i_dpr_user_b.op(1, 0, 14'h7, 32'h0, 4'h0);
        join
        chk("a shared read", 36'h6_0F1E_2D3C, {a_po, a_do});
        chk("b shared read", 36'h6_0F1E_2D3C, {b_po, b_do});
        bus(0, 12'h008, 0);
        chk("op count end", 36'h0_000B_0004, {4'h0, r});
        $display("polarity done");
        test_done();
    end
endmodule : testbench
